// *** rtl/acs_adc_ctrl.sv ***
// Purpose: converter control, pin select, sequencer and sleep behaviour
// Assumes: core sleep is a level input; comparator is synchronous
// Notes:   read data appear in the cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none

module acs_adc_ctrl (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // register port
  input  wire acs_pkg::acs_bus_req_t busReq,
  output logic [7:0]                 busRdata,
  // core power state
  input  wire logic                  coreSleep,
  output logic                       wakeReq,
  output logic                       irq,
  // analog front end
  input  wire logic                  compHigh,
  output logic [9:0]                 dacCode,
  output acs_pkg::acs_analog_t       analog
);

  acs_pkg::acs_regs_t r_q;
  acs_pkg::acs_regs_t r_d;
  logic               tadTick;
  logic               running;
  logic               rcSel;
  logic               ctrlWr;
  logic [7:0]         wdCtrl;

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock

  assign running = r_q.st != acs_pkg::ACS_IDLE &&
                   r_q.st != acs_pkg::ACS_WAIT;
  assign rcSel   = acs_pkg::isRc(r_q.pinClk[acs_pkg::PCS_CLK_LO +: 3]);

  acs_tad_gen u_tad (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clkSel   (r_q.pinClk[acs_pkg::PCS_CLK_LO +: 3]),
    .run      (running),
    .tadTick  (tadTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // result placement by justify bit
  function automatic logic [15:0] placeResult(input logic [9:0] res,
                                               input logic rightJust);
    if (rightJust)
      return {6'h00, res[9:8], res[7:0]};
    else
      return {res[9:2], res[1:0], 6'h00};
  endfunction

  assign ctrlWr = busReq.wr && busReq.addr == acs_pkg::ADDR_CTRL;
  assign wdCtrl = busReq.wdata & acs_pkg::CTRL_WMASK;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [15:0] placed;
    logic        goSet;
    logic        goClr;
    logic [1:0]  evt;
    placed = placeResult(r_q.sar, r_q.ctrl[acs_pkg::CTRL_JUSTIFY]);
    goSet  = 1'b0;
    goClr  = 1'b0;
    evt    = 2'h0;
    r_d    = r_q;
    r_d.wake = 1'b0;

    // register reads
    r_d.rdata = 8'h00;
    if (busReq.rd) begin
      case (busReq.addr)
        acs_pkg::ADDR_CTRL:     r_d.rdata = r_q.ctrl;
        acs_pkg::ADDR_PIN_CLK:  r_d.rdata = r_q.pinClk;
        acs_pkg::ADDR_RES_HIGH: r_d.rdata = r_q.resHigh;
        acs_pkg::ADDR_RES_LOW:  r_d.rdata = r_q.resLow;
        acs_pkg::ADDR_IRQ_STAT: r_d.rdata = {6'h00, r_q.irqStat};
        acs_pkg::ADDR_IRQ_MASK: r_d.rdata = {6'h00, r_q.irqMask};
        default:                r_d.rdata = 8'h00;
      endcase
    end

    // register writes
    if (busReq.wr) begin
      case (busReq.addr)
        acs_pkg::ADDR_PIN_CLK:
          r_d.pinClk = busReq.wdata & acs_pkg::PCS_WMASK;
        acs_pkg::ADDR_IRQ_MASK:
          r_d.irqMask = busReq.wdata[1:0];
        acs_pkg::ADDR_IRQ_STAT:
          r_d.irqStat = r_q.irqStat & ~busReq.wdata[1:0];
        default: ;
      endcase
    end
    if (ctrlWr) begin
      r_d.ctrl    = {wdCtrl[7:2], r_q.ctrl[acs_pkg::CTRL_GO], wdCtrl[0]};
      r_d.pwrDown = 1'b0;           // a control register write restores power
      // go only takes when the converter was already on
      goSet = wdCtrl[acs_pkg::CTRL_GO] && r_q.ctrl[acs_pkg::CTRL_ON] &&
              wdCtrl[acs_pkg::CTRL_ON];
      goClr = !wdCtrl[acs_pkg::CTRL_GO] || !wdCtrl[acs_pkg::CTRL_ON];
    end

    // sequencer
    case (r_q.st)
      acs_pkg::ACS_IDLE: begin
        if (goSet) begin
          r_d.ctrl[acs_pkg::CTRL_GO] = 1'b1;
          r_d.waitCnt = 3'(acs_pkg::INSTR_CYCLES - 1);
          r_d.st = rcSel ? acs_pkg::ACS_WAIT : acs_pkg::ACS_SETUP;
        end
      end
      acs_pkg::ACS_WAIT: begin
        if (r_q.waitCnt == 3'h0)
          r_d.st = acs_pkg::ACS_SETUP;
        else
          r_d.waitCnt = r_q.waitCnt - 3'h1;
      end
      acs_pkg::ACS_SETUP: begin
        if (tadTick) begin
          r_d.sar    = 10'h200;
          r_d.bitIdx = 4'(acs_pkg::RESULT_BITS - 1);
          r_d.st     = acs_pkg::ACS_CONV;
        end
      end
      acs_pkg::ACS_CONV: begin
        if (tadTick) begin
          r_d.sar[r_q.bitIdx] = compHigh;
          if (r_q.bitIdx != 4'h0) begin
            r_d.sar[r_q.bitIdx - 4'h1] = 1'b1;
            r_d.bitIdx = r_q.bitIdx - 4'h1;
          end else begin
            r_d.st = acs_pkg::ACS_IDLE;
            r_d.ctrl[acs_pkg::CTRL_GO] = 1'b0;
            evt[acs_pkg::IRQ_DONE] = 1'b1;
            placed = placeResult(r_d.sar,
                                 r_q.ctrl[acs_pkg::CTRL_JUSTIFY]);
            r_d.resHigh = placed[15:8];
            r_d.resLow  = placed[7:0];
            if (coreSleep) begin
              if (r_q.irqMask[acs_pkg::IRQ_DONE])
                r_d.wake = 1'b1;
              else
                r_d.pwrDown = 1'b1;
            end
          end
        end
      end
      acs_pkg::ACS_HOLDOFF: begin
        if (tadTick) begin
          if (r_q.tadCnt == 2'h0)
            r_d.st = acs_pkg::ACS_IDLE;
          else
            r_d.tadCnt = r_q.tadCnt - 2'h1;
        end
      end
      default: r_d.st = acs_pkg::ACS_IDLE;
    endcase

    if (r_q.st != acs_pkg::ACS_IDLE && r_q.st != acs_pkg::ACS_HOLDOFF &&
        goClr) begin
      r_d.ctrl[acs_pkg::CTRL_GO] = 1'b0;
      r_d.resHigh = r_q.resHigh;
      r_d.resLow  = r_q.resLow;
      r_d.tadCnt  = 2'(acs_pkg::ABORT_TADS - 1);
      r_d.st      = acs_pkg::ACS_HOLDOFF;
      r_d.wake    = 1'b0;
      r_d.pwrDown = 1'b0;
      evt         = 2'h0;
      evt[acs_pkg::IRQ_ABORT] = 1'b1;
    end

    // only the rc source survives sleep
    if (coreSleep && !rcSel && r_q.st != acs_pkg::ACS_IDLE &&
        r_q.st != acs_pkg::ACS_HOLDOFF) begin
      r_d.ctrl[acs_pkg::CTRL_GO] = 1'b0;
      r_d.resHigh = r_q.resHigh;
      r_d.resLow  = r_q.resLow;
      r_d.pwrDown = 1'b1;
      r_d.wake    = 1'b0;
      r_d.st      = acs_pkg::ACS_IDLE;
      evt         = 2'h0;
      evt[acs_pkg::IRQ_ABORT] = 1'b1;
    end

    // sticky flags, set wins over clear
    r_d.irqStat = r_d.irqStat | evt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r_q         <= '0;
      r_q.ctrl    <= acs_pkg::CTRL_RESET;
      r_q.pinClk  <= acs_pkg::PCS_RESET;
      r_q.resHigh <= acs_pkg::RES_RESET;
      r_q.resLow  <= acs_pkg::RES_RESET;
      r_q.irqStat <= acs_pkg::IRQ_RESET;
      r_q.irqMask <= acs_pkg::IRQ_RESET;
      r_q.st      <= acs_pkg::ACS_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign irq      = |(r_q.irqStat & r_q.irqMask);
  assign busRdata = r_q.rdata;
  assign wakeReq  = r_q.wake;
  assign dacCode  = r_q.sar;

  assign analog.analogPins = r_q.pinClk[3:0];
  assign analog.channel    = r_q.ctrl[acs_pkg::CTRL_CHAN_LO +: 2];
  assign analog.vrefPin    = r_q.ctrl[acs_pkg::CTRL_VREF];
  // powered follows on-bit unless forced down
  assign analog.powered    = r_q.ctrl[acs_pkg::CTRL_ON] && !r_q.pwrDown;

endmodule
`default_nettype wire

// *** rtl/acs_pkg.sv ***
// Purpose: constants and types for the converter pin, clock and sleep control
// Assumes: 10 MHz core clock, byte-wide register port
// Notes:   register offsets are byte addresses on the register port
//
// Overview of operation
// - clock select picks core clock /2,/4,/8,/16,/32,/64 or internal RC
// - conversion resolves input into 1024 steps, a 10-bit result
// - conversion survives sleep only on the internal RC clock source
// - with RC source, start waits one instruction cycle after go
// - completion in sleep clears go and loads both result registers
// - completion in sleep wakes the core when converter irq is enabled
// - completion in sleep without irq enable powers down, on-bit stays set
// - sleep with a non-RC clock aborts and powers down, on-bit stays set
// - go starts a conversion; completion clears go, sets flag, raises irq when enabled
// - an aborted conversion leaves the result registers unchanged

package acs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADDR_RES_HIGH  = 8'h1E;
  localparam logic [7:0] ADDR_CTRL      = 8'h1F;
  localparam logic [7:0] ADDR_RES_LOW   = 8'h9E;
  localparam logic [7:0] ADDR_PIN_CLK   = 8'h9F;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'hA1;

  // converter_control fields
  localparam int CTRL_JUSTIFY = 7;
  localparam int CTRL_VREF    = 6;
  localparam int CTRL_CHAN_LO = 2;
  localparam int CTRL_GO      = 1;
  localparam int CTRL_ON      = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hCF;  // bits 5:4 read as zero

  // analog_pin_and_clock_select fields
  localparam int PCS_CLK_LO = 4;
  localparam logic [7:0] PCS_WMASK = 8'h7F;   // bit 7 reads as zero

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PCS_RESET  = 8'h0F;
  localparam logic [7:0] RES_RESET  = 8'h00;
  localparam logic [1:0] IRQ_RESET  = 2'h0;

  // interrupt status bits
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ABORT = 1;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CORE_CLK_KHZ  = 10000;
  localparam int RC_PERIOD_NS  = 4000;        // typical RC period
  localparam int RC_DIV = (RC_PERIOD_NS * CORE_CLK_KHZ) / 1000000;
  localparam int INSTR_CYCLES  = 4;           // one instruction cycle
  localparam int RESULT_BITS   = 10;
  localparam int ABORT_TADS    = 2;           // holdoff after abort

  // conversion clock select codes
  localparam logic [2:0] CLK_DIV2  = 3'h0;
  localparam logic [2:0] CLK_DIV8  = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV4  = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ACS_IDLE    = 3'b000,
    ACS_WAIT    = 3'b001,
    ACS_SETUP   = 3'b010,
    ACS_CONV    = 3'b011,
    ACS_HOLDOFF = 3'b100
  } acs_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acs_bus_req_t;

  typedef struct packed {
    logic [3:0] analogPins;
    logic [1:0] channel;
    logic       vrefPin;
    logic       powered;
  } acs_analog_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] pinClk;
    logic [7:0] resHigh;
    logic [7:0] resLow;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
    logic [7:0] rdata;
    acs_state_t st;
    logic [9:0] sar;
    logic [3:0] bitIdx;
    logic [2:0] waitCnt;
    logic [1:0] tadCnt;
    logic       pwrDown;
    logic       wake;
  } acs_regs_t;

  // true when the RC oscillator is the conversion clock (x11)
  function automatic logic isRc(input logic [2:0] sel);
    return sel[1:0] == 2'h3;
  endfunction

endpackage

// *** rtl/acs_tad_gen.sv ***
// Purpose: conversion clock tick from core clock divider or RC oscillator
// Assumes: one core clock domain; RC modelled as a free-running divider
// Notes:   tick is one core clock wide, once per conversion clock period
`timescale 1ns/100ps
`default_nettype none

module acs_tad_gen (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // control
  input  wire logic [2:0] clkSel,
  input  wire logic       run,
  // tick
  output logic            tadTick
);

  logic [5:0] divCnt_q;
  logic [5:0] divCnt_d;
  logic [5:0] rcCnt_q;
  logic [5:0] rcCnt_d;
  logic [5:0] divLast;
  logic       rcTick;

  always_comb begin
    case (clkSel)
      acs_pkg::CLK_DIV2:  divLast = 6'h01;
      acs_pkg::CLK_DIV4:  divLast = 6'h03;
      acs_pkg::CLK_DIV8:  divLast = 6'h07;
      acs_pkg::CLK_DIV16: divLast = 6'h0F;
      acs_pkg::CLK_DIV32: divLast = 6'h1F;
      acs_pkg::CLK_DIV64: divLast = 6'h3F;
      default:            divLast = 6'h3F;
    endcase
  end

  // rc oscillator runs free of the core
  assign rcTick  = rcCnt_q == 6'(acs_pkg::RC_DIV - 1);
  assign rcCnt_d = rcTick ? 6'h00 : rcCnt_q + 6'h01;
  assign divCnt_d = (!run || divCnt_q == divLast) ? 6'h00
                                                  : divCnt_q + 6'h01;

  // divider registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt_q <= 6'h00;
      rcCnt_q  <= 6'h00;
    end else begin
      divCnt_q <= divCnt_d;
      rcCnt_q  <= rcCnt_d;
    end
  end

  assign tadTick = run && (acs_pkg::isRc(clkSel) ? rcTick
                                                 : divCnt_q == divLast);

endmodule
`default_nettype wire

// *** verification/acs_adc_chk.sv ***
// Purpose: port assertions for the converter control block
// Assumes: one core clock, asynchronous active-low reset
// Notes:   watches top-level ports only; attached by bind at the foot
`timescale 1ns/100ps
`default_nettype none

module acs_adc_chk (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  nrst,
  // register port
  input wire acs_pkg::acs_bus_req_t busReq,
  input wire logic [7:0]            busRdata,
  // power state and analog side
  input wire logic                  coreSleep,
  input wire logic                  wakeReq,
  input wire logic                  irq,
  input wire acs_pkg::acs_analog_t  analog
);
  // decoded write strobes
  logic pcsWr;
  logic ctrlWr;
  logic maskWr;
  assign pcsWr  = busReq.wr && busReq.addr == acs_pkg::ADDR_PIN_CLK;
  assign ctrlWr = busReq.wr && busReq.addr == acs_pkg::ADDR_CTRL;
  assign maskWr = busReq.wr && busReq.addr == acs_pkg::ADDR_IRQ_MASK;

  // every check runs on the core clock, off during reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  a_pins_follow: assert property (
    pcsWr |=> analog.analogPins == $past(busReq.wdata[3:0]))
    else $error("pin select did not follow write");
  a_pcs_bit7: assert property (
    busReq.rd && busReq.addr == acs_pkg::ADDR_PIN_CLK |=> !busRdata[7])
    else $error("clock select bit 7 read as one");
  a_chan_follow: assert property (
    ctrlWr |=> analog.channel == $past(busReq.wdata[3:2])
      && analog.vrefPin == $past(busReq.wdata[6]))
    else $error("channel or reference did not follow write");
  a_off_unpowered: assert property (
    ctrlWr && !busReq.wdata[0] |=> !analog.powered)
    else $error("converter powered while switched off");
  a_on_powered: assert property (
    ctrlWr && busReq.wdata[0] && !coreSleep |=> analog.powered)
    else $error("converter not powered after switch on");
  a_wake_cause: assert property (
    wakeReq |-> coreSleep && irq)
    else $error("wake without sleep or pending interrupt");
  a_wake_pulse: assert property (
    wakeReq |=> !wakeReq)
    else $error("wake request longer than one cycle");
  a_irq_masked: assert property (
    maskWr && busReq.wdata[1:0] == 2'h0 |=> !irq)
    else $error("interrupt high with all sources masked");
endmodule

bind acs_adc_ctrl acs_adc_chk u_acs_adc_chk (
  .core_clk  (core_clk),
  .nrst      (nrst),
  .busReq    (busReq),
  .busRdata  (busRdata),
  .coreSleep (coreSleep),
  .wakeReq   (wakeReq),
  .irq       (irq),
  .analog    (analog)
);

`default_nettype wire

// *** verification/acs_adc_ctrl_bench.sv ***
// Purpose: self-checking bench for the converter control block
// Assumes: comparator modelled from a random input level
// Notes:   every register access takes two cycles
`timescale 1ns/100ps
`default_nettype none

module acs_adc_ctrl_bench;
  logic                  core_clk;
  logic                  nrst;
  acs_pkg::acs_bus_req_t busReq;
  logic [7:0]            busRdata;
  logic                  coreSleep;
  logic                  wakeReq;
  logic                  irq;
  logic                  compHigh;
  logic [9:0]            dacCode;
  acs_pkg::acs_analog_t  analog;
  logic [7:0]            rv;
  logic [9:0]            vin;
  logic [9:0]            vp;
  logic [3:0]            pn;
  logic [1:0]            ch;
  logic                  woke;
  logic [7:0]            ra [7] = '{8'h1F, 8'h9F, 8'h1E, 8'h9E, 8'hA0,
                                    8'hA1, 8'h55};
  logic [7:0]            rx [7] = '{8'h00, 8'h0F, 8'h00, 8'h00, 8'h00,
                                    8'h00, 8'h00};
  int                    err_count, checks_done, t0, n, i, lo, hi;
  int                    cyc = 0;
  // core cycles allowed for one full input acquisition period
  localparam int         ACQ_CYCLES = 200;

  acs_adc_ctrl u_acs_adc_ctrl (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .busReq    (busReq),
    .busRdata  (busRdata),
    .coreSleep (coreSleep),
    .wakeReq   (wakeReq),
    .irq       (irq),
    .compHigh  (compHigh),
    .dacCode   (dacCode),
    .analog    (analog)
  );

  ////////////////////////////////////////////////////////////////////////////
  // core clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // comparator model, cycle count and wake capture
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    compHigh <= vin >= dacCode;
    if (wakeReq === 1'b1)
      woke <= 1'b1;
  end

  task automatic chk(input logic [9:0] g, e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // one access, read data caught in the cycle after the strobe
  task automatic acc(input logic w, input logic [7:0] a, d);
    busReq <= '{a, d, w, !w};
    @(posedge core_clk);
    busReq <= '0;
    #1 rv = busRdata;
    @(posedge core_clk);
  endtask

  task automatic rchk(input logic [7:0] a, e);
    acc(1'b0, a, 8'h00);
    chk(10'(rv), 10'(e));
  endtask

  // set clock and pins, pick a channel, switch on, settle, then start
  task automatic conv(input logic [2:0] s, input logic j);
    vin = s == 3'h0 ? 10'h3FF : s == 3'h4 ? 10'h000 : 10'($urandom);
    pn = 4'($urandom);
    ch = 2'($urandom);
    acc(1'b1, acs_pkg::ADDR_PIN_CLK, {1'b1, s, pn});
    acc(1'b1, acs_pkg::ADDR_CTRL, {j, 3'h0, ch, 2'h1});
    repeat (ACQ_CYCLES) @(posedge core_clk);
    acc(1'b1, acs_pkg::ADDR_CTRL, {j, 3'h0, ch, 2'h3});
    t0 = cyc;
  endtask

  // poll until the go flag drops, bounded
  task automatic wdone;
    n = 0;
    do begin
      acc(1'b0, acs_pkg::ADDR_CTRL, 8'h00);
      n++;
    end while (rv[1] !== 1'b0 && n < 1000);
    chk(10'(rv[1]), 10'h0);
  endtask

  task automatic cres(input logic j, input logic [9:0] v);
    rchk(acs_pkg::ADDR_RES_HIGH, j ? {6'h00, v[9:8]} : v[9:2]);
    rchk(acs_pkg::ADDR_RES_LOW, j ? v[7:0] : {v[1:0], 6'h00});
  endtask

  // conversion clock period in core cycles
  function automatic int dv(input logic [2:0] s);
    if (s[1:0] == 2'h3)
      return acs_pkg::RC_DIV;
    return 2 << (2 * s[1:0] + s[2]);
  endfunction

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog, far beyond the expected run
  initial begin
    #3000000;
    err_count++;
    wrap_up;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    busReq = '0;
    coreSleep = 1'b0;
    compHigh = 1'b0;
    vin = 10'h000;
    woke = 1'b0;
    err_count = 0;
    checks_done = 0;
    void'($urandom(65));
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // reset values and an unmapped read
    for (i = 0; i < 7; i++)
      rchk(ra[i], rx[i]);
    acc(1'b1, acs_pkg::ADDR_IRQ_MASK, 8'h01);
    // every clock code, both result layouts
    for (i = 0; i < 8; i++) begin
      conv(i[2:0], i[0]);
      wdone;
      lo = 10 * dv(i[2:0]) + (i % 4 == 3 ? acs_pkg::INSTR_CYCLES : 0);
      hi = lo + dv(i[2:0]) + 6;
      chk(10'((cyc - t0) >= lo - 2 && (cyc - t0) <= hi), 10'h1);
      cres(i[0], vin);
      rchk(acs_pkg::ADDR_PIN_CLK, {1'b0, i[2:0], pn});
      chk(10'(analog.analogPins), 10'(pn));
      chk(10'(analog.channel), 10'(ch));
      rchk(acs_pkg::ADDR_IRQ_STAT, 8'h01);
      chk(10'(irq), 10'h1);
      acc(1'b1, acs_pkg::ADDR_IRQ_STAT, 8'h01);
      chk(10'(irq), 10'h0);
    end
    // software abort keeps the previous result
    vp = vin;
    conv(3'h6, 1'b1);
    repeat (100) @(posedge core_clk);
    acc(1'b1, acs_pkg::ADDR_CTRL, 8'h81);
    cres(1'b1, vp);
    rchk(acs_pkg::ADDR_IRQ_STAT, 8'h02);
    acc(1'b1, acs_pkg::ADDR_IRQ_STAT, 8'h03);
    repeat (140) @(posedge core_clk);
    // sleep on a divided clock aborts and powers down
    conv(3'h5, 1'b1);
    coreSleep <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(10'(analog.powered), 10'h0);
    rchk(acs_pkg::ADDR_CTRL, {1'b1, 3'h0, ch, 2'h1});
    cres(1'b1, vp);
    coreSleep <= 1'b0;
    acc(1'b1, acs_pkg::ADDR_IRQ_STAT, 8'h03);
    repeat (40) @(posedge core_clk);
    // RC conversion finishes in sleep and wakes the core
    woke = 1'b0;
    conv(3'h3, 1'b0);
    coreSleep <= 1'b1;
    for (n = 0; n < 600 && !woke; n++)
      @(posedge core_clk);
    chk(10'(woke), 10'h1);
    coreSleep <= 1'b0;
    rchk(acs_pkg::ADDR_CTRL, {1'b0, 3'h0, ch, 2'h1});
    cres(1'b0, vin);
    acc(1'b1, acs_pkg::ADDR_IRQ_STAT, 8'h01);
    // no wake without the enable, converter powers down
    acc(1'b1, acs_pkg::ADDR_IRQ_MASK, 8'h00);
    woke = 1'b0;
    conv(3'h7, 1'b1);
    coreSleep <= 1'b1;
    repeat (600) @(posedge core_clk);
    chk(10'({woke, analog.powered, irq}), 10'h0);
    rchk(acs_pkg::ADDR_CTRL, {1'b1, 3'h0, ch, 2'h1});
    cres(1'b1, vin);
    coreSleep <= 1'b0;
    acc(1'b1, acs_pkg::ADDR_CTRL, 8'h00);
    chk(10'(analog.powered), 10'h0);
    wrap_up;
  end
endmodule

`default_nettype wire
